// *** tb/madbg_assertions.sv ***
// Bus and command-word checker for the debug register bank
`timescale 1ns/1ps
`default_nettype none
module madbg_assertions
    import madbg_pkg::*;
#(
    parameter int GW = GAIN_W
)
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic [WB_AW-1:0]  wb_adr_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic              wb_we_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              wb_err_o,
    input wire logic [GW-1:0]     inner_prop_gain_used,
    input wire logic [GW-1:0]     inner_integ_gain_used,
    input wire logic [CODE_W-1:0] forced_d_axis_voltage,
    input wire madbg_meas_t       meas_cmd,
    input wire logic              commit_measured_to_shadow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    // Full-word writes only, so every lane of the command word is loaded
    sequence s_wc;
        s_take ##0 wb_we_i && wb_sel_i == 4'hf && {2'b00, wb_adr_i[11:2]} == IDX_CMD;
    endsequence
    property p_answer;
        s_take |=> wb_ack_o || wb_err_o;
    endproperty
    a_answer: assert property (p_answer) else $error("no bus answer");
    property p_drop;
        wb_ack_o |=> !wb_ack_o && !wb_err_o;
    endproperty
    a_drop: assert property (p_drop) else $error("ack held");
    property p_ro;
        s_take ##0 wb_we_i && {2'b00, wb_adr_i[11:2]} == IDX_CUR_STATUS |=> wb_err_o;
    endproperty
    a_ro: assert property (p_ro) else $error("status write accepted");
    property p_start;
        s_wc ##0 wb_dat_i[MEAS_START_BIT] |=> meas_cmd.start ##1 !meas_cmd.start;
    endproperty
    a_start: assert property (p_start) else $error("start pulse wrong");
    property p_commit;
        s_wc |=> commit_measured_to_shadow == $past(wb_dat_i[COMMIT_BIT]);
    endproperty
    a_commit: assert property (p_commit) else $error("commit wrong");
    property p_vd;
        s_wc |=> forced_d_axis_voltage == $past(wb_dat_i[25:16]);
    endproperty
    a_vd: assert property (p_vd) else $error("d code wrong");
    property p_sel;
        s_wc |=> meas_cmd[3:0] == $past(wb_dat_i[4:1]);
    endproperty
    a_sel: assert property (p_sel) else $error("measure enables wrong");
    property p_cur;
        s_take ##0 !wb_we_i && {2'b00, wb_adr_i[11:2]} == IDX_CUR_STATUS |=> wb_dat_o ==
            {$past(inner_prop_gain_used), $past(inner_integ_gain_used), 12'h000};
    endproperty
    a_cur: assert property (p_cur) else $error("current gains wrong");
    property p_keep;
        s_take ##0 wb_we_i && !wb_sel_i[0] && {2'b00, wb_adr_i[11:2]} == IDX_CMD
            |=> !commit_measured_to_shadow && !meas_cmd.start;
    endproperty
    a_keep: assert property (p_keep) else $error("stale pulse fired");
endmodule
bind madbg_regs madbg_assertions #(.GW(GW)) u_chk (.clk, .rst_b, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .inner_prop_gain_used, .inner_integ_gain_used, .forced_d_axis_voltage, .meas_cmd,
    .commit_measured_to_shadow);
`default_nettype wire

// *** tb/tb_top.sv ***
// Random and corner-case bench for the debug register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top import madbg_pkg::*;;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [39:0] g = '0;
    logic [31:0] dat_o, rd, w;
    logic [3:0]  sel = 4'hf;
    logic [39:0] gc;
    logic        ack, err, er, ilb, olb, com;
    logic [9:0]  fd, fq, c, q;
    madbg_mod_t  vd, vq;
    madbg_meas_t mc;
    logic [5:0]  m;
    int          err_count = 0;
    int          tests_run = 0;
    logic [9:0]  cn [6] = '{10'h000, 10'h001, 10'h1f3, 10'h1f4, 10'h200, 10'h3e8};
    always #25 clk = ~clk;
    madbg_regs uut (.clk(clk), .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(req), .wb_stb_i(req), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .inner_prop_gain_used(g[9:0]),
        .inner_integ_gain_used(g[19:10]), .outer_prop_gain_used(g[29:20]),
        .outer_integ_gain_used(g[39:30]), .inner_loop_bypass(ilb), .outer_loop_bypass(olb),
        .vd_mod(vd), .vq_mod(vq), .forced_d_axis_voltage(fd), .forced_q_axis_voltage(fq),
        .meas_cmd(mc), .commit_measured_to_shadow(com), .gain_cfg(gc));
    task automatic conclude;
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        tests_run++;
        if (s !== e)
        begin
            err_count++;
            $display("ERROR %0t saw %h expected %h", $time, s, e);
        end
    endtask
    // Reads the pre-edge values, so ack and pulses are seen at the edge they are sampled
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        chk(n < 20, 1'b1);
        rd = dat_o;
        er = err;
        req <= 1'b0;
    endtask
    function automatic madbg_mod_t mexp(input logic [9:0] k);
        madbg_mod_t r;
        r.valid = k < 10'h1f4 || k > 10'h200;
        r.mod_num = k < 10'h1f4 ? {1'b0, k} : (k > 10'h200 ? 11'h200 - {1'b0, k} : 11'h000);
        return r;
    endfunction
    // Codes 501..511 are outside what software may write
    function automatic logic [9:0] rc();
        logic [9:0] k;
        k = 10'($urandom_range(1000));
        if (k > 10'h1f4 && k < 10'h200)
            k = 10'h200;
        return k;
    endfunction
    initial
    begin
        #1000000;
        err_count++;
        conclude();
    end
    initial
    begin
        int i;
        void'($urandom(23));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        chk({vd, vq, mc, com, fd, fq}, '0);
        for (i = 0; i < 2; i++)
        begin
            wb(1'b1, 12'h380, 32'(i) << BYPASS_BIT);
            chk({ilb, olb}, {2{i[0]}});
        end
        wb(1'b0, 12'h380, '0);
        chk(rd, 32'h1 << BYPASS_BIT);
        for (i = 0; i < 16; i++)
        begin
            c = i < 6 ? cn[i] : rc();
            q = i < 6 ? cn[5 - i] : rc();
            m = 6'($urandom);
            wb(1'b1, 12'h3b8, {6'h00, c, q, m});
            chk(fd, c);
            chk(vd, mexp(c));
            chk(fq, q);
            chk(vq, mexp(q));
            chk(mc, m[5:1]);
            chk(com, m[0]);
        end
        wb(1'b1, 12'h3c0, '1);
        chk(er, 1'b1);
        wb(1'b0, 12'h7fc, '0);
        chk(er, 1'b1);
        // A later write that leaves lane 0 out must not fire start or commit again
        wb(1'b1, 12'h3b8, {6'h00, c, q, 6'h21});
        chk({com, mc}, 6'h30);
        sel <= 4'hc;
        wb(1'b1, 12'h3b8, {6'h00, 10'h155, 10'h3ff, 6'h3f});
        sel <= 4'hf;
        chk({com, mc}, 6'h00);
        chk(fd, 10'h155);
        chk(vd, mexp(10'h155));
        chk(fq, q);
        w = $urandom;
        wb(1'b1, 12'h388, w);
        chk(gc, {8'h00, w});
        wb(1'b0, 12'h388, '0);
        chk(rd, w);
        wb(1'b0, 12'h3b8, '0);
        chk(rd, '0);
        for (i = 0; i < 4; i++)
        begin
            g <= 40'({$urandom, $urandom});
            wb(1'b0, 12'h3c0, '0);
            chk(rd, {g[9:0], g[19:10], 12'h000});
            wb(1'b0, 12'h3c8, '0);
            chk(rd, {g[29:20], g[39:30], 12'h000});
        end
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk({vd, vq, mc, com, fd, fq}, '0);
        chk({ilb, olb, gc}, '0);
        conclude();
    end
endmodule
`default_nettype wire

// *** verilog/madbg_pkg.sv ***
// Package for the motor debug and parameter-measure register bank
package madbg_pkg;
    localparam int          WB_AW            = 12;
    // Printed offsets are word indices; byte address is four times the index
    localparam logic [11:0] IDX_CMD          = 12'h0ee;
    localparam logic [11:0] IDX_CUR_STATUS   = 12'h0f0;
    localparam logic [11:0] IDX_SPD_STATUS   = 12'h0f2;
    localparam logic [11:0] IDX_BYPASS_CTRL  = 12'h0e0;
    localparam logic [11:0] IDX_GAIN_CFG     = 12'h0e2;
    localparam int          VD_LSB           = 16;
    localparam int          VQ_LSB           = 6;
    localparam int          MEAS_START_BIT   = 5;
    localparam int          MEAS_R_BIT       = 4;
    localparam int          MEAS_L_BIT       = 3;
    localparam int          MEAS_KE_BIT      = 2;
    localparam int          MEAS_MECH_BIT    = 1;
    localparam int          COMMIT_BIT       = 0;
    localparam int          BYPASS_BIT       = 18;
    localparam int          KP_LSB           = 22;
    localparam int          KI_LSB           = 12;
    localparam int          GAIN_W           = 10;
    localparam int          CODE_W           = 10;
    localparam logic [9:0]  CODE_POS_LIMIT   = 10'h1f4;
    localparam logic [9:0]  CODE_NEG_BASE    = 10'h200;
    localparam logic [31:0] ZERO_WORD        = 32'h00000000;

    typedef struct packed {
        logic                  valid;
        logic signed [10:0]    mod_num;
    } madbg_mod_t;

    typedef struct packed {
        logic       start;
        logic       meas_r;
        logic       meas_l;
        logic       meas_ke;
        logic       meas_mech;
    } madbg_meas_t;
endpackage

// *** verilog/madbg_regs.sv ***
// Debug command word, forced voltages and controller gain readback
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module madbg_regs
    import madbg_pkg::*;
#(
    parameter int GW = GAIN_W
)
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [WB_AW-1:0]  wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic              wb_we_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   wb_err_o,
    input  wire logic [GW-1:0]     inner_prop_gain_used,
    input  wire logic [GW-1:0]     inner_integ_gain_used,
    input  wire logic [GW-1:0]     outer_prop_gain_used,
    input  wire logic [GW-1:0]     outer_integ_gain_used,
    output logic                   inner_loop_bypass,
    output logic                   outer_loop_bypass,
    output madbg_mod_t             vd_mod,
    output madbg_mod_t             vq_mod,
    output logic [CODE_W-1:0]      forced_d_axis_voltage,
    output logic [CODE_W-1:0]      forced_q_axis_voltage,
    output madbg_meas_t            meas_cmd,
    output logic                   commit_measured_to_shadow,
    output logic [4*GW-1:0]        gain_cfg
);

    logic [31:0]         wmask;
    logic [31:0]         wr_bits;
    logic                req;
    logic [WB_AW-3:0]    idx;
    logic                hit_cmd;
    logic                hit_cur;
    logic                hit_spd;
    logic                hit_byp;
    logic                hit_cfg;
    logic                rd_ok;
    logic                wr_ok;
    logic                take_rd;
    logic                take_wr;
    logic                wr_cmd;
    logic                wr_byp;
    logic                wr_cfg;
    logic [31:0]         cmd_word;
    logic [31:0]         cmd_q;
    logic [31:0]         rd_d;
    logic [31:0]         cfg_word;
    logic [CODE_W-1:0]   vd_code;
    logic [CODE_W-1:0]   vq_code;
    logic                start_d;
    logic                commit_d;

    // Codes 500..512 carry no modulation; valid drops so the loop can ignore them
    function automatic madbg_mod_t decode_code(input logic [CODE_W-1:0] code);
        madbg_mod_t m;
        m.valid   = 1'b1;
        m.mod_num = 11'sh000;
        if (code < CODE_POS_LIMIT)
            m.mod_num = $signed({1'b0, code});
        else if (code > CODE_NEG_BASE)
            m.mod_num = -$signed({1'b0, code - CODE_NEG_BASE});
        else
            m.valid = 1'b0;
        return m;
    endfunction

    // Status layout: kp on top, ki below it, low bits zero
    function automatic logic [31:0] gain_word(input logic [GW-1:0] kp,
                                              input logic [GW-1:0] ki);
        logic [31:0] w;
        w = ZERO_WORD;
        w[KP_LSB +: GW] = kp;
        w[KI_LSB +: GW] = ki;
        return w;
    endfunction

    // Indices that answer a read; the command word reads back as zero
    function automatic logic readable(input logic [WB_AW-3:0] i);
        logic ok;
        ok = 1'b0;
        case (i)
            IDX_CMD[WB_AW-3:0],
            IDX_CUR_STATUS[WB_AW-3:0],
            IDX_SPD_STATUS[WB_AW-3:0],
            IDX_BYPASS_CTRL[WB_AW-3:0],
            IDX_GAIN_CFG[WB_AW-3:0]:
                ok = 1'b1;
            default:
                ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Status words are read-only, so only these take writes
    function automatic logic writable(input logic [WB_AW-3:0] i);
        logic ok;
        ok = 1'b0;
        case (i)
            IDX_CMD[WB_AW-3:0],
            IDX_BYPASS_CTRL[WB_AW-3:0],
            IDX_GAIN_CFG[WB_AW-3:0]:
                ok = 1'b1;
            default:
                ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Index taken from the word address; byte lanes picked by sel
    assign idx      = wb_adr_i[WB_AW-1:2];
    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit_cmd  = idx == IDX_CMD[WB_AW-3:0];
    assign hit_cur  = idx == IDX_CUR_STATUS[WB_AW-3:0];
    assign hit_spd  = idx == IDX_SPD_STATUS[WB_AW-3:0];
    assign hit_byp  = idx == IDX_BYPASS_CTRL[WB_AW-3:0];
    assign hit_cfg  = idx == IDX_GAIN_CFG[WB_AW-3:0];
    assign rd_ok    = readable(idx);
    assign wr_ok    = writable(idx);
    assign take_rd  = req && !wb_we_i && rd_ok;
    assign take_wr  = req && wb_we_i && wr_ok;
    assign wr_cmd   = take_wr && hit_cmd;
    assign wr_byp   = take_wr && hit_byp;
    assign wr_cfg   = take_wr && hit_cfg;

    generate
        for (genvar b = 0; b < 4; b++)
        begin : g_mask
            assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
        end
    endgenerate

    // Merge keeps unselected lanes; wr_bits holds only what is written now
    assign cmd_word = (cmd_q & ~wmask) | (wb_dat_i & wmask);
    assign wr_bits  = wb_dat_i & wmask;
    assign cfg_word = (gain_cfg[31:0] & ~wmask) | wr_bits;
    assign vd_code  = cmd_word[VD_LSB +: CODE_W];
    assign vq_code  = cmd_word[VQ_LSB +: CODE_W];

    // Pulses look only at lanes written now, so a stale one in cmd_q cannot fire again
    assign start_d  = wr_cmd && wr_bits[MEAS_START_BIT];
    assign commit_d = wr_cmd && wr_bits[COMMIT_BIT];

    // Read mux; the command word is write-only and reads as zero
    always_comb
    begin
        rd_d = ZERO_WORD;
        if (hit_cur)
            rd_d = gain_word(inner_prop_gain_used, inner_integ_gain_used);
        else if (hit_spd)
            rd_d = gain_word(outer_prop_gain_used, outer_integ_gain_used);
        else if (hit_byp)
            rd_d[BYPASS_BIT] = inner_loop_bypass;
        else if (hit_cfg)
            rd_d = gain_cfg[31:0];
    end

    // Ack one cycle after the request; the !ack term in req drops it the cycle after
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= take_rd || take_wr;
    end

    // Unmapped index or a write to a status word is refused and changes nothing
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            wb_err_o <= 1'b0;
        else
            wb_err_o <= req && !take_rd && !take_wr;
    end

    // Read data stands with ack only; zero otherwise so stale words never leak
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            wb_dat_o <= ZERO_WORD;
        else if (take_rd)
            wb_dat_o <= rd_d;
        else
            wb_dat_o <= ZERO_WORD;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cmd_q <= ZERO_WORD;
        else if (wr_cmd)
            cmd_q <= cmd_word;
    end

    // Forced d-axis code and its modulation, held until the next write
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            forced_d_axis_voltage <= '0;
            vd_mod                <= '0;
        end
        else if (wr_cmd)
        begin
            forced_d_axis_voltage <= vd_code;
            vd_mod                <= decode_code(vd_code);
        end
    end

    // Forced q-axis code uses the same encoding as the d-axis one
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            forced_q_axis_voltage <= '0;
            vq_mod                <= '0;
        end
        else if (wr_cmd)
        begin
            forced_q_axis_voltage <= vq_code;
            vq_mod                <= decode_code(vq_code);
        end
    end

    // Start pulses for one cycle; enables latch on every command write
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            meas_cmd <= '0;
        else
        begin
            meas_cmd.start <= start_d;
            if (wr_cmd)
            begin
                meas_cmd.meas_r    <= cmd_word[MEAS_R_BIT];
                meas_cmd.meas_l    <= cmd_word[MEAS_L_BIT];
                meas_cmd.meas_ke   <= cmd_word[MEAS_KE_BIT];
                meas_cmd.meas_mech <= cmd_word[MEAS_MECH_BIT];
            end
        end
    end

    // Commit is a one-cycle pulse so the shadow copy happens once per write
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            commit_measured_to_shadow <= 1'b0;
        else
            commit_measured_to_shadow <= commit_d;
    end

    // One bypass bit drives both loops off so forced voltages reach the motor
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            inner_loop_bypass <= 1'b0;
        else if (wr_byp && wb_sel_i[BYPASS_BIT/8])
            inner_loop_bypass <= wb_dat_i[BYPASS_BIT];
    end

    // Speed loop follows the same bit
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            outer_loop_bypass <= 1'b0;
        else if (wr_byp && wb_sel_i[BYPASS_BIT/8])
            outer_loop_bypass <= wb_dat_i[BYPASS_BIT];
    end

    // Configured gains: kp_in, ki_in, kp_out, ki_out from low bits up.
    // Only 32 bits reach the bus, so the top of ki_out stays zero.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            gain_cfg <= '0;
        else if (wr_cfg)
            gain_cfg <= {{(4*GW-32){1'b0}}, cfg_word};
    end

endmodule
`default_nettype wire
